// File: hdl/hioc_cfg.svh
// Register map, field positions, reset values and timing counts
`ifndef HIOC_CFG_SVH
`define HIOC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define HIOC_OFS_IDENT    8'h50
`define HIOC_OFS_CFG      8'h54
`define HIOC_OFS_STS      8'h58
`define HIOC_OFS_EN       8'h5C
`define HIOC_OFS_BTEST    8'h64

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define HIOC_HOLD_MSB     31
`define HIOC_HOLD_LSB     24
`define HIOC_RESTART_BIT  14
`define HIOC_ACTIVE_BIT   13
`define HIOC_MASTER_BIT   12
`define HIOC_EN_BIT       8
`define HIOC_POL_BIT      4
`define HIOC_TYPE_BIT     0
`define HIOC_PWR_EVT_BIT  17
`define HIOC_STS_MASK     32'h83BFE000
`define HIOC_RESET_WORD   32'h00000000
`define HIOC_BTEST_VALUE  32'h87654321

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HIOC_STEP_NS      10000
`define HIOC_CLK_NS       40
`define HIOC_STEP_CYCLES  ((`HIOC_STEP_NS + `HIOC_CLK_NS - 1) / `HIOC_CLK_NS)

`endif

// File: hdl/hioc_holdoff_timer.sv
// Hold-off interval timer counted in fixed steps
`timescale 1ns/1ps
`include "hioc_cfg.svh"

module hioc_holdoff_timer #(
  parameter int STEP_CYCLES = `HIOC_STEP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       cancel,
  input  wire logic [7:0] interval,
  output logic            active
);

  if (STEP_CYCLES < 1 || STEP_CYCLES > 65536) begin : g_bad_step
    $error("hioc_holdoff_timer: STEP_CYCLES out of range");
  end

  hioc_pkg::hioc_hold_state_type state_reg, state_next;
  logic [15:0]                   pre_reg, pre_next;
  logic [7:0]                    steps_reg, steps_next;
  logic [7:0]                    limit_reg, limit_next;
  logic [7:0]                    steps_inc;
  logic [23:0]                   elapsed_reg;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pre_next   = pre_reg;
    steps_next = steps_reg;
    limit_next = limit_reg;
    steps_inc  = steps_reg + 8'h01;
    if (cancel) begin
      state_next = hioc_pkg::HIOC_IDLE;
      pre_next   = 16'h0000;
      steps_next = 8'h00;
    end else if (start) begin
      state_next = (interval != 8'h00) ? hioc_pkg::HIOC_RUN : hioc_pkg::HIOC_IDLE;
      pre_next   = 16'h0000;
      steps_next = 8'h00;
      limit_next = interval;
    end else begin
      case (state_reg)
        hioc_pkg::HIOC_RUN: begin
          if (pre_reg == 16'(STEP_CYCLES - 1)) begin
            pre_next   = 16'h0000;
            steps_next = steps_inc;
            if (steps_inc == limit_reg) begin
              state_next = hioc_pkg::HIOC_IDLE;
            end
          end else begin
            pre_next = pre_reg + 16'h0001;
          end
        end
        hioc_pkg::HIOC_IDLE: begin
          pre_next = 16'h0000;
        end
        default: begin
          state_next = hioc_pkg::HIOC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= hioc_pkg::HIOC_IDLE;
      pre_reg   <= 16'h0000;
      steps_reg <= 8'h00;
      limit_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      pre_reg   <= pre_next;
      steps_reg <= steps_next;
      limit_reg <= limit_next;
    end
  end

  assign active = (state_reg == hioc_pkg::HIOC_RUN);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_reg <= 24'h000000;
    end else if (start || cancel) begin
      elapsed_reg <= 24'h000000;
    end else if (active) begin
      elapsed_reg <= elapsed_reg + 24'h000001;
    end
  end

  property p_hold_length;
    @(posedge clk) disable iff (!rst_n)
      $fell(active) && !$past(start) && !$past(cancel)
        |-> elapsed_reg == 24'(limit_reg * STEP_CYCLES);
  endproperty
  a_hold_length: assert property (p_hold_length)
    else $error("hold-off interval has wrong length");

  property p_cancel_idle;
    @(posedge clk) disable iff (!rst_n)
      cancel |=> !active;
  endproperty
  a_cancel_idle: assert property (p_cancel_idle)
    else $error("cancel did not stop the interval");

endmodule

// File: hdl/hioc_pkg.sv
// Types shared by the interrupt output controller
package hioc_pkg;

  // Configuration held by the controller
  typedef struct packed {
    logic [7:0] holdoff_interval;
    logic       irq_en;
    logic       output_polarity;
    logic       push_pull;
  } hioc_cfg_type;

  // One captured host write
  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] data;
  } hioc_req_type;

  // Hold-off timer states
  typedef enum logic [0:0] {
    HIOC_IDLE = 1'b0,
    HIOC_RUN  = 1'b1
  } hioc_hold_state_type;

endpackage

// File: hdl/hioc_top.sv
// Host interrupt output controller with hold-off and identity registers
`timescale 1ns/1ps
`include "hioc_cfg.svh"

// Function
// - 8-bit hold-off interval, 10 us steps
// - zero interval cancels and releases pending interrupts
// - new interval applies to later interrupts
// - power event bypasses hold-off
// - restart bit begins fresh interval
// - active bit withholds pin during interval
// - master bit shows any enabled source
// - disabled output keeps pin deasserted
// - polarity bit selects push-pull level
// - buffer bit selects open-drain or push-pull
// - identity register holds chip and revision
// - byte-order register returns fixed pattern
// - three interrupt registers, reset to zero
// - polarity and buffer bits survive soft reset
// - writing one acknowledges a status bit
module hioc_top #(
  parameter logic [15:0] CHIP_ID     = 16'h0A5A,
  parameter logic [15:0] CHIP_REV    = 16'h0001,
  parameter logic [31:0] STS_MASK    = `HIOC_STS_MASK,
  parameter int          STEP_CYCLES = `HIOC_STEP_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        SOFT_RESET,
  input  wire logic        CS_N,
  input  wire logic        RD_N,
  input  wire logic        WR_N,
  input  wire logic [5:0]  ADDR,
  input  wire logic [31:0] DATA_IN,
  output logic      [31:0] DATA_OUT,
  output logic             DATA_OE,
  input  wire logic [31:0] EVENT_IN,
  output logic             IRQ_OUT,
  output logic             IRQ_OE
);

  // CHIP_ID and CHIP_REV defaults are arbitrary values
  if (STEP_CYCLES < 1 || STEP_CYCLES > 65536) begin : g_bad_step
    $error("hioc_top: STEP_CYCLES out of range");
  end

  default clocking hioc_cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  localparam logic [31:0] PWR_MASK = 32'h00000001 << `HIOC_PWR_EVT_BIT;

  function automatic logic hit(input logic [5:0] a, input logic [7:0] ofs);
    hit = (a == ofs[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]             ctl_meta_reg, ctl_sync_reg;
  hioc_pkg::hioc_req_type bus_meta_reg, bus_sync_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_meta_reg <= 3'h7;
      ctl_sync_reg <= 3'h7;
      bus_meta_reg <= '0;
      bus_sync_reg <= '0;
    end else begin
      ctl_meta_reg <= {CS_N, RD_N, WR_N};
      ctl_sync_reg <= ctl_meta_reg;
      bus_meta_reg <= {ADDR, DATA_IN};
      bus_sync_reg <= bus_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  logic                   rd_act, wr_act, wr_take;
  logic                   wr_prev_reg, wr_prev_next;
  hioc_pkg::hioc_req_type req_reg, req_next;

  assign rd_act = ~ctl_sync_reg[2] & ~ctl_sync_reg[1];
  assign wr_act = ~ctl_sync_reg[2] & ~ctl_sync_reg[0];
  assign wr_take = wr_prev_reg & ~wr_act;

  always_comb begin
    wr_prev_next = wr_act;
    req_next     = wr_act ? bus_sync_reg : req_reg;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_prev_reg <= 1'b0;
      req_reg     <= '0;
    end else begin
      wr_prev_reg <= wr_prev_next;
      req_reg     <= req_next;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  hioc_pkg::hioc_cfg_type cfg_reg, cfg_next;
  logic [31:0]            sts_reg, sts_next;
  logic [31:0]            en_reg, en_next;
  logic                   restart_reg, restart_next;
  logic                   cancel_reg, cancel_next;
  logic                   wr_cfg, wr_sts, wr_en;
  logic [31:0]            events;

  assign wr_cfg = wr_take & hit(req_reg.addr, `HIOC_OFS_CFG);
  assign wr_sts = wr_take & hit(req_reg.addr, `HIOC_OFS_STS);
  assign wr_en  = wr_take & hit(req_reg.addr, `HIOC_OFS_EN);
  assign events = EVENT_IN & STS_MASK;

  always_comb begin
    cfg_next     = cfg_reg;
    en_next      = en_reg;
    restart_next = 1'b0;
    cancel_next  = 1'b0;
    sts_next = (sts_reg & ~((wr_sts ? req_reg.data : 32'h00000000) & STS_MASK)) | events;
    if (SOFT_RESET) begin
      // soft reset spares polarity and buffer type
      cfg_next.holdoff_interval = 8'h00;
      cfg_next.irq_en           = 1'b0;
      sts_next    = `HIOC_RESET_WORD;
      en_next     = `HIOC_RESET_WORD;
      cancel_next = 1'b1;
    end else begin
      if (wr_cfg) begin
        cfg_next.holdoff_interval = req_reg.data[`HIOC_HOLD_MSB:`HIOC_HOLD_LSB];
        cfg_next.irq_en           = req_reg.data[`HIOC_EN_BIT];
        cfg_next.output_polarity  = req_reg.data[`HIOC_POL_BIT];
        cfg_next.push_pull        = req_reg.data[`HIOC_TYPE_BIT];
        restart_next = req_reg.data[`HIOC_RESTART_BIT];
        cancel_next = (req_reg.data[`HIOC_HOLD_MSB:`HIOC_HOLD_LSB] == 8'h00);
      end
      if (wr_en) begin
        en_next = req_reg.data & STS_MASK;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_reg     <= '0;
      sts_reg     <= `HIOC_RESET_WORD;
      en_reg      <= `HIOC_RESET_WORD;
      restart_reg <= 1'b0;
      cancel_reg  <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      sts_reg     <= sts_next;
      en_reg      <= en_next;
      restart_reg <= restart_next;
      cancel_reg  <= cancel_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output path
  // ----------------------------------------------------------------
  logic master, other_hit, pwr_hit, assert_now, hold_active, hold_start;
  logic assert_reg, assert_next;
  logic irq_out_reg, irq_out_next;
  logic irq_oe_reg, irq_oe_next;

  assign master    = |(sts_reg & en_reg);
  assign other_hit = |(sts_reg & en_reg & ~PWR_MASK);
  assign pwr_hit   = |(sts_reg & en_reg & PWR_MASK);
  // enable gate, power event skips hold-off
  assign assert_now = cfg_reg.irq_en & ((other_hit & ~hold_active) | pwr_hit);
  assign hold_start = restart_reg | (assert_reg & ~assert_now & cfg_reg.irq_en);

  hioc_holdoff_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .clk      (CLK),
    .rst_n    (RST_N),
    .start    (hold_start),
    .cancel   (cancel_reg),
    .interval (cfg_reg.holdoff_interval),
    .active   (hold_active)
  );

  always_comb begin
    assert_next = assert_now;
    if (cfg_reg.push_pull) begin
      irq_out_next = cfg_reg.output_polarity ? assert_now : ~assert_now;
      irq_oe_next  = 1'b1;
    end else begin
      irq_out_next = 1'b0;
      irq_oe_next  = assert_now;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      assert_reg  <= 1'b0;
      irq_out_reg <= 1'b0;
      irq_oe_reg  <= 1'b0;
    end else begin
      assert_reg  <= assert_next;
      irq_out_reg <= irq_out_next;
      irq_oe_reg  <= irq_oe_next;
    end
  end

  assign IRQ_OUT = irq_out_reg;
  assign IRQ_OE  = irq_oe_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rd_word, data_out_reg, data_out_next;
  logic        data_oe_reg, data_oe_next;

  always_comb begin
    rd_word = 32'h00000000;
    if (hit(bus_sync_reg.addr, `HIOC_OFS_IDENT)) begin
      rd_word = {CHIP_ID, CHIP_REV};
    end else if (hit(bus_sync_reg.addr, `HIOC_OFS_CFG)) begin
      rd_word[`HIOC_HOLD_MSB:`HIOC_HOLD_LSB] = cfg_reg.holdoff_interval;
      rd_word[`HIOC_ACTIVE_BIT] = hold_active;
      rd_word[`HIOC_MASTER_BIT] = master;
      rd_word[`HIOC_EN_BIT]     = cfg_reg.irq_en;
      rd_word[`HIOC_POL_BIT]    = cfg_reg.output_polarity;
      rd_word[`HIOC_TYPE_BIT]   = cfg_reg.push_pull;
    end else if (hit(bus_sync_reg.addr, `HIOC_OFS_STS)) begin
      rd_word = sts_reg;
    end else if (hit(bus_sync_reg.addr, `HIOC_OFS_EN)) begin
      rd_word = en_reg;
    end else if (hit(bus_sync_reg.addr, `HIOC_OFS_BTEST)) begin
      rd_word = `HIOC_BTEST_VALUE;
    end
    data_out_next = rd_act ? rd_word : 32'h00000000;
    data_oe_next  = rd_act;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_out_reg <= 32'h00000000;
      data_oe_reg  <= 1'b0;
    end else begin
      data_out_reg <= data_out_next;
      data_oe_reg  <= data_oe_next;
    end
  end

  assign DATA_OUT = data_out_reg;
  assign DATA_OE  = data_oe_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_disabled_quiet;
      !cfg_reg.irq_en |=> !assert_reg;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("pin asserted while output disabled");
  property p_open_drain;
      !cfg_reg.push_pull |=> !IRQ_OUT && (IRQ_OE == assert_reg);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin driven wrongly");
  property p_push_pull;
      cfg_reg.push_pull |=> IRQ_OE && (IRQ_OUT == ($past(cfg_reg.output_polarity) ~^ assert_reg));
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull level wrong for polarity");
  property p_pin_cause;
      assert_reg |-> $past(master && cfg_reg.irq_en && (!hold_active || pwr_hit));
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("pin asserted without cause");
  property p_hold_withholds;
      $rose(assert_reg) |-> $past(!hold_active || pwr_hit);
  endproperty
  a_hold_withholds: assert property (p_hold_withholds)
    else $error("pin rose during hold-off interval");
  property p_pwr_bypass;
      pwr_hit && cfg_reg.irq_en |=> assert_reg;
  endproperty
  a_pwr_bypass: assert property (p_pwr_bypass)
    else $error("power event delayed by hold-off");
  property p_ack_clears;
      wr_sts && !SOFT_RESET |=> (sts_reg & $past(req_reg.data & STS_MASK & ~events)) == 32'h0;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("acknowledged status bit not cleared");
  property p_soft_keep;
      SOFT_RESET |=> (cfg_reg.output_polarity == $past(cfg_reg.output_polarity))
        && (cfg_reg.push_pull == $past(cfg_reg.push_pull)) && !cfg_reg.irq_en;
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("soft reset disturbed buffer settings");
  property p_soft_zero;
      SOFT_RESET |=> sts_reg == 32'h0 && en_reg == 32'h0 && cfg_reg.holdoff_interval == 8'h00;
  endproperty
  a_soft_zero: assert property (p_soft_zero)
    else $error("registers not zero after soft reset");
  property p_zero_cancels;
      wr_cfg && !SOFT_RESET && req_reg.data[`HIOC_HOLD_MSB:`HIOC_HOLD_LSB] == 8'h00
        |-> ##2 !hold_active;
  endproperty
  a_zero_cancels: assert property (p_zero_cancels)
    else $error("zero interval did not cancel hold-off");
  property p_restart;
      wr_cfg && !SOFT_RESET && req_reg.data[`HIOC_RESTART_BIT]
        && req_reg.data[`HIOC_HOLD_MSB:`HIOC_HOLD_LSB] != 8'h00 ##1 !SOFT_RESET
        |-> ##1 hold_active;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not begin an interval");
  property p_byte_test;
      rd_act && hit(bus_sync_reg.addr, `HIOC_OFS_BTEST) |=> DATA_OUT == `HIOC_BTEST_VALUE;
  endproperty
  a_byte_test: assert property (p_byte_test)
    else $error("byte-order pattern wrong");

endmodule

// File: tb/hioc_host_model.sv
// Host processor model: SRAM-like bus master and pulled-up interrupt line
`timescale 1ns/1ps

module hioc_host_model (
  input  wire logic        clk,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic      [5:0]  addr,
  output logic      [31:0] data_in,
  input  wire logic        data_oe,
  input  wire logic        irq_out,
  input  wire logic        irq_oe,
  output logic             irq_line
);
  // ----------------------------------------------------------------
  // Wire level with pull-up
  // ----------------------------------------------------------------
  assign irq_line = irq_oe ? irq_out : 1'h1;

  initial begin
    cs_n    = 1'h1;
    rd_n    = 1'h1;
    wr_n    = 1'h1;
    addr    = 6'h00;
    data_in = 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // acknowledge by writing ones
  task automatic bus_write(input logic [7:0] ofs, input logic [31:0] d);
    @(posedge clk);
    addr    <= ofs[7:2];
    data_in <= d;
    repeat (2) @(posedge clk);
    cs_n <= 1'h0;
    wr_n <= 1'h0;
    repeat (4) @(posedge clk);
    cs_n <= 1'h1;
    wr_n <= 1'h1;
    repeat (5) @(posedge clk);
    data_in <= ~d;
  endtask

  task automatic bus_read(input logic [7:0] ofs);
    int n;
    @(posedge clk);
    addr <= ofs[7:2];
    repeat (2) @(posedge clk);
    cs_n <= 1'h0;
    rd_n <= 1'h0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (data_oe !== 1'h1 && n < 10);
    cs_n <= 1'h1;
    rd_n <= 1'h1;
    repeat (4) @(posedge clk);
  endtask
endmodule

// File: tb/tb_host_irq_output_control.sv
// Self-checking bench of the host interrupt output controller
`timescale 1ns/1ps
`include "hioc_cfg.svh"

module tb_host_irq_output_control;
  localparam int          STEP     = 2;
  // Identity values are arbitrary
  localparam logic [15:0] ID_CODE  = 16'h3C3C;
  localparam logic [15:0] REV_CODE = 16'h0007;
  localparam logic [31:0] EV_A     = 32'h00002000;
  localparam logic [31:0] EV_PWR   = 32'h00020000;
  localparam logic [31:0] MASK     = `HIOC_STS_MASK;

  logic        CLK        = 1'h0;
  logic        RST_N      = 1'h0;
  logic        SOFT_RESET = 1'h0;
  logic [31:0] EVENT_IN   = 32'h00000000;
  logic        CS_N;
  logic        RD_N;
  logic        WR_N;
  logic [5:0]  ADDR;
  logic [31:0] DATA_IN;
  logic [31:0] DATA_OUT;
  logic        DATA_OE;
  logic        IRQ_OUT;
  logic        IRQ_OE;
  logic        irq_line;
  logic        oe_d       = 1'h0;
  logic        pol        = 1'h0;
  logic        typ        = 1'h0;
  logic [31:0] lfsr       = 32'hBCF90AC6;
  logic [31:0] en_v;
  logic [31:0] ev_v;
  logic [31:0] ack_v;
  logic [31:0] exp_q [$];
  string       name_q [$];
  int          mismatches  = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  int          t0;
  logic [7:0]  ofs_t [6]   = '{`HIOC_OFS_IDENT, `HIOC_OFS_CFG, `HIOC_OFS_STS,
                               `HIOC_OFS_EN, `HIOC_OFS_BTEST, 8'h60};
  logic [31:0] exp_t [6]   = '{{ID_CODE, REV_CODE}, 32'h0, 32'h0, 32'h0,
                               `HIOC_BTEST_VALUE, 32'h0};

  always #20 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;

  hioc_top #(.CHIP_ID(ID_CODE), .CHIP_REV(REV_CODE), .STEP_CYCLES(STEP)) uut (
    .CLK(CLK), .RST_N(RST_N), .SOFT_RESET(SOFT_RESET), .CS_N(CS_N), .RD_N(RD_N),
    .WR_N(WR_N), .ADDR(ADDR), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .EVENT_IN(EVENT_IN), .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE));

  hioc_host_model host (
    .clk(CLK), .cs_n(CS_N), .rd_n(RD_N), .wr_n(WR_N), .addr(ADDR),
    .data_in(DATA_IN), .data_oe(DATA_OE),
    .irq_out(IRQ_OUT), .irq_oe(IRQ_OE), .irq_line(irq_line));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] lfsr_next();
    lfsr = {lfsr[30:0], 1'h0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
    return lfsr;
  endfunction

  function automatic logic [31:0] cfgw(input logic [7:0] h, input logic act, mst, en);
    return {h, 9'h000, 1'h0, act, mst, 3'h0, en, 3'h0, pol, 3'h0, typ};
  endfunction

  task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
    exp_q.push_back(exp);
    name_q.push_back($sformatf("read %h", ofs));
    host.bus_read(ofs);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    host.bus_write(ofs, d);
  endtask

  task automatic ev(input logic [31:0] v);
    @(posedge CLK);
    EVENT_IN <= v;
    @(posedge CLK);
    EVENT_IN <= 32'h0;
    repeat (2) @(posedge CLK);
  endtask

  task automatic check_pin(input logic on);
    @(negedge CLK);
    check("pin level", {31'h0, (typ & pol) ? on : ~on}, {31'h0, irq_line});
    check("pin enable", {31'h0, typ | on}, {31'h0, IRQ_OE});
  endtask

  task automatic wait_assert(input int lo, input int hi);
    int n;
    n = 0;
    while (irq_line !== 1'h1 && n < 400) begin
      @(posedge CLK);
      n++;
    end
    check("hold-off span", 32'h1, {31'h0, (cyc - t0 >= lo) && (cyc - t0 <= hi)});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Read result watcher
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    oe_d <= DATA_OE;
    if (DATA_OE === 1'h1 && oe_d !== 1'h1 && exp_q.size() > 0)
      check(name_q.pop_front(), exp_q.pop_front(), DATA_OUT);
  end

  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CLK);
    RST_N <= 1'h1;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++)
        rd(ofs_t[i], exp_t[i]);
      wr(`HIOC_OFS_IDENT, 32'hFFFFFFFF);
      wr(`HIOC_OFS_BTEST, 32'hFFFFFFFF);
      wr(8'h60, 32'hFFFFFFFF);
    end
    $display("test registers done");
    wr(`HIOC_OFS_EN, EV_A | EV_PWR);
    ev(EV_A);
    check_pin(1'h0);
    rd(`HIOC_OFS_CFG, cfgw(8'h00, 1'h0, 1'h1, 1'h0));
    rd(`HIOC_OFS_STS, EV_A);
    wr(`HIOC_OFS_STS, EV_A);
    for (int k = 0; k < 3; k++) begin
      typ = (k > 0);
      pol = (k == 2);
      wr(`HIOC_OFS_CFG, cfgw(8'h00, 1'h0, 1'h0, 1'h1));
      check_pin(1'h0);
      ev(EV_A);
      check_pin(1'h1);
      wr(`HIOC_OFS_STS, 32'h00000000);
      check_pin(1'h1);
      wr(`HIOC_OFS_STS, EV_A);
      check_pin(1'h0);
    end
    $display("test pin modes done");
    for (int r = 0; r < 4; r++) begin
      en_v = lfsr_next();
      wr(`HIOC_OFS_EN, en_v);
      ev_v = lfsr_next();
      ev(ev_v);
      rd(`HIOC_OFS_EN, en_v & MASK);
      rd(`HIOC_OFS_STS, ev_v & MASK);
      rd(`HIOC_OFS_CFG, cfgw(8'h00, 1'h0, |(en_v & ev_v & MASK), 1'h1));
      ack_v = lfsr_next();
      wr(`HIOC_OFS_STS, ack_v);
      rd(`HIOC_OFS_STS, ev_v & MASK & ~ack_v);
      wr(`HIOC_OFS_STS, 32'hFFFFFFFF);
    end
    $display("test random status done");
    wr(`HIOC_OFS_EN, EV_A | EV_PWR);
    wr(`HIOC_OFS_CFG, cfgw(8'h14, 1'h0, 1'h0, 1'h1));
    ev(EV_A);
    check_pin(1'h1);
    wr(`HIOC_OFS_STS, EV_A);
    t0 = cyc;
    ev(EV_A);
    check_pin(1'h0);
    rd(`HIOC_OFS_CFG, cfgw(8'h14, 1'h1, 1'h1, 1'h1));
    wait_assert(38, 44);
    wr(`HIOC_OFS_STS, EV_A);
    repeat (20) @(posedge CLK);
    ev(EV_A);
    wr(`HIOC_OFS_CFG, cfgw(8'h14, 1'h0, 1'h0, 1'h1) | 32'h00004000);
    t0 = cyc;
    wait_assert(36, 44);
    $display("test hold-off done");
    wr(`HIOC_OFS_STS, EV_A);
    ev(EV_PWR);
    check_pin(1'h1);
    wr(`HIOC_OFS_STS, EV_PWR);
    ev(EV_A);
    check_pin(1'h0);
    wr(`HIOC_OFS_CFG, cfgw(8'h00, 1'h0, 1'h0, 1'h1));
    repeat (2) @(posedge CLK);
    check_pin(1'h1);
    wr(`HIOC_OFS_CFG, cfgw(8'h05, 1'h0, 1'h0, 1'h1));
    wr(`HIOC_OFS_STS, EV_A);
    t0 = cyc;
    ev(EV_A);
    wait_assert(9, 14);
    $display("test bypass and cancel done");
    @(posedge CLK);
    SOFT_RESET <= 1'h1;
    @(posedge CLK);
    SOFT_RESET <= 1'h0;
    rd(`HIOC_OFS_CFG, cfgw(8'h00, 1'h0, 1'h0, 1'h0));
    rd(`HIOC_OFS_STS, 32'h0);
    check_pin(1'h0);
    check("read queue", 32'h0, exp_q.size());
    $display("test soft reset done");
    complete_run();
  end
endmodule
